// [hdl/swsub_defines.svh]
// Function
// - Immediate form: literal minus W into W
// - Positive result (literal above W): carry set, zero clear, negative from result bit 7
// - Zero result: zero and carry set, negative clear
// - Borrow (literal below W): two's-complement result, carry clear, negative from result bit 7
// - Extended set: low access addresses use indexed offset
`ifndef SWSUB_DEFINES_SVH
`define SWSUB_DEFINES_SVH
`define SWSUB_OPC_IMM 8'h08
`define SWSUB_OPC_FILE 6'h17
`define SWSUB_IDX_LIMIT 8'h5F
`define SWSUB_ACCESS_SPLIT 8'h60
`define SWSUB_ACCESS_HI_BANK 4'hF
`define SWSUB_W_RESET 8'h00
`define SWSUB_FLAGS_RESET 5'h00
`define SWSUB_ACCESS_LO_BANK 4'h0
`define SWSUB_DATA_RESET 8'h00
`define SWSUB_ADDR_RESET 12'h000
`define SWSUB_OPC_MSB 15
`define SWSUB_IMM_OPC_LSB 8
`define SWSUB_FILE_OPC_LSB 10
`define SWSUB_DEST_BIT 9
`define SWSUB_ACCESS_BIT 8
`define SWSUB_OPERAND_MSB 7
`define SWSUB_OPERAND_LSB 0
`define SWSUB_FLAG_C 0
`define SWSUB_FLAG_DIGIT 1
`define SWSUB_FLAG_Z 2
`define SWSUB_FLAG_OVERFLOW 3
`define SWSUB_FLAG_N 4
`endif

// [hdl/swsub_pkg.sv]
package swsub_pkg;
  // Four instruction phases
  typedef enum logic [1:0] {
    SWSUB_Q1_DECODE,
    SWSUB_Q2_READ,
    SWSUB_Q3_PROCESS,
    SWSUB_Q4_WRITE
  } swsub_phase_t;
endpackage : swsub_pkg

// [hdl/swsub_alu.sv]
`timescale 1ns/1ps
`include "swsub_defines.svh"
// Subtractor: minuend minus subtrahend with the five status flags
module swsub_alu (
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  output logic [7:0] diff,
  output logic [4:0] flags
);
  logic [8:0] full; // Ninth bit is inverted borrow
  logic [4:0] low_nib; // Nibble subtract for digit carry
  // Two's-complement subtract and flag derivation
  always_comb begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    low_nib = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    diff = full[7:0];
    flags = 5'h00;
    flags[`SWSUB_FLAG_C] = full[8];
    flags[`SWSUB_FLAG_DIGIT] = low_nib[4];
    flags[`SWSUB_FLAG_Z] = (full[7:0] == 8'h00);
    flags[`SWSUB_FLAG_N] = full[7];
    flags[`SWSUB_FLAG_OVERFLOW] = (minuend[7] != subtrahend[7]) && (full[7] != minuend[7]);
  end
endmodule : swsub_alu

// [hdl/swsub_exec.sv]
`timescale 1ns/1ps
`include "swsub_defines.svh"
// Executes both subtract instructions across four phases
module swsub_exec
  import swsub_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic instr_valid, // Sampled in decode phase
  input wire logic [15:0] instr_word, // Single-word instruction
  input wire logic ext_set_en, // Extended instruction set enabled
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base, // Indexed offset base pointer
  input wire logic [7:0] file_rdata, // File read data, valid in read phase
  output logic [11:0] file_addr, // File address
  output logic file_rd, // Read strobe in read phase
  output logic file_wr, // Write strobe, registered: high in the decode-phase cycle that follows the write phase
  output logic [7:0] file_wdata,
  output logic [7:0] w_out, // Working register
  output logic [4:0] status_out, // Negative, overflow, zero, digit carry, carry
  output logic busy // High outside decode phase
);
  // Phase sequencer state
  swsub_phase_t phase_r; // Current instruction phase
  swsub_phase_t phase_nxt; // Phase for the next cycle
  logic active_r; // An accepted instruction is in flight
  logic active_nxt;
  // Operand capture state
  logic is_imm_r; // Accepted instruction is the immediate form
  logic is_imm_nxt;
  logic dest_r; // Destination bit: 0 working register, 1 file register
  logic dest_nxt;
  logic [11:0] addr_r; // Effective file address
  logic [11:0] addr_nxt;
  logic [7:0] opa_r; // Minuend: literal or file operand
  logic [7:0] opa_nxt;
  // Result state
  logic [7:0] res_r; // Difference held for the write phase
  logic [7:0] res_nxt;
  logic [4:0] rflags_r; // Flags held for the write phase
  logic [4:0] rflags_nxt;
  // Architectural state and file write port
  logic [7:0] w_r; // Working register
  logic [7:0] w_nxt;
  logic [4:0] flags_r; // Status flags
  logic [4:0] flags_nxt;
  logic wr_r; // File write strobe
  logic wr_nxt;
  logic [7:0] wdata_r; // File write data
  logic [7:0] wdata_nxt;
  // Decode and subtractor results
  logic take_imm; // Immediate form accepted this cycle
  logic take_file; // Register form accepted this cycle
  logic [7:0] alu_diff; // Subtractor difference
  logic [4:0] alu_flags; // Subtractor flags

  // True when the word encodes the immediate-form subtract
  function automatic logic swsub_is_imm(input logic [15:0] iw);
    swsub_is_imm = (iw[`SWSUB_OPC_MSB:`SWSUB_IMM_OPC_LSB] == `SWSUB_OPC_IMM);
  endfunction : swsub_is_imm

  // True when the word encodes the register-form subtract
  function automatic logic swsub_is_file(input logic [15:0] iw);
    swsub_is_file = (iw[`SWSUB_OPC_MSB:`SWSUB_FILE_OPC_LSB] == `SWSUB_OPC_FILE);
  endfunction : swsub_is_file

  // Forms the effective file address from f, a and mode
  function automatic logic [11:0] swsub_eff_addr(input logic [7:0] f, input logic a,
                                                 input logic ext, input logic [3:0] bank,
                                                 input logic [11:0] base);
    if (a) begin
      // Banked access through the bank select register
      swsub_eff_addr = {bank, f};
    end else if (ext && (f <= `SWSUB_IDX_LIMIT)) begin
      // Indexed literal offset from the base pointer
      swsub_eff_addr = base + 12'(f);
    end else if (f < `SWSUB_ACCESS_SPLIT) begin
      // Low half of the access bank
      swsub_eff_addr = {`SWSUB_ACCESS_LO_BANK, f};
    end else begin
      // High half of the access bank
      swsub_eff_addr = {`SWSUB_ACCESS_HI_BANK, f};
    end
  endfunction : swsub_eff_addr

  swsub_alu u_alu (
    .minuend(opa_r),
    .subtrahend(w_r),
    .diff(alu_diff),
    .flags(alu_flags)
  );

  // Opcode decode, honoured only while waiting in the decode phase
  always_comb begin
    take_imm = 1'b0;
    take_file = 1'b0;
    if ((phase_r == SWSUB_Q1_DECODE) && instr_valid) begin
      take_imm = swsub_is_imm(instr_word);
      take_file = swsub_is_file(instr_word);
    end
  end

  // Phase sequencer: one instruction occupies four phases
  always_comb begin
    phase_nxt = phase_r;
    active_nxt = active_r;
    unique case (phase_r)
      SWSUB_Q1_DECODE: begin
        // Leave decode only for a recognised subtract
        active_nxt = take_imm || take_file;
        if (take_imm || take_file) begin
          phase_nxt = SWSUB_Q2_READ;
        end
      end
      SWSUB_Q2_READ: begin
        // Operand read
        phase_nxt = SWSUB_Q3_PROCESS;
      end
      SWSUB_Q3_PROCESS: begin
        // Subtract
        phase_nxt = SWSUB_Q4_WRITE;
      end
      SWSUB_Q4_WRITE: begin
        // Write back, then wait for the next word
        phase_nxt = SWSUB_Q1_DECODE;
      end
    endcase
  end

  // Phase sequencer registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phase_r <= SWSUB_Q1_DECODE;
      active_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      active_r <= active_nxt;
    end
  end

  // Operand capture: literal in decode, file byte at the end of read
  always_comb begin
    is_imm_nxt = is_imm_r;
    dest_nxt = dest_r;
    addr_nxt = addr_r;
    opa_nxt = opa_r;
    if (take_imm) begin
      // Literal becomes the minuend
      is_imm_nxt = 1'b1;
      opa_nxt = instr_word[`SWSUB_OPERAND_MSB:`SWSUB_OPERAND_LSB];
    end else if (take_file) begin
      // Latch destination and form the file address
      is_imm_nxt = 1'b0;
      dest_nxt = instr_word[`SWSUB_DEST_BIT];
      addr_nxt = swsub_eff_addr(instr_word[`SWSUB_OPERAND_MSB:`SWSUB_OPERAND_LSB],
                                instr_word[`SWSUB_ACCESS_BIT], ext_set_en,
                                bank_select_register, index_base);
    end else if ((phase_r == SWSUB_Q2_READ) && !is_imm_r) begin
      // File operand becomes the minuend
      opa_nxt = file_rdata;
    end
  end

  // Operand capture registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      is_imm_r <= 1'b0;
      dest_r <= 1'b0;
      addr_r <= `SWSUB_ADDR_RESET;
      opa_r <= `SWSUB_DATA_RESET;
    end else begin
      is_imm_r <= is_imm_nxt;
      dest_r <= dest_nxt;
      addr_r <= addr_nxt;
      opa_r <= opa_nxt;
    end
  end

  // Result capture at the end of the process phase
  always_comb begin
    res_nxt = res_r;
    rflags_nxt = rflags_r;
    if (phase_r == SWSUB_Q3_PROCESS) begin
      res_nxt = alu_diff;
      rflags_nxt = alu_flags;
    end
  end

  // Result registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      res_r <= `SWSUB_DATA_RESET;
      rflags_r <= `SWSUB_FLAGS_RESET;
    end else begin
      res_r <= res_nxt;
      rflags_r <= rflags_nxt;
    end
  end

  // Write back: working register or file register, flags in every case
  always_comb begin
    w_nxt = w_r;
    flags_nxt = flags_r;
    wdata_nxt = wdata_r;
    wr_nxt = 1'b0; // Strobe lasts one cycle
    if ((phase_r == SWSUB_Q4_WRITE) && active_r) begin
      flags_nxt = rflags_r;
      if (is_imm_r || !dest_r) begin
        // Destination is the working register
        w_nxt = res_r;
      end else begin
        // Destination is the file register
        wr_nxt = 1'b1;
        wdata_nxt = res_r;
      end
    end
  end

  // Write-back registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      w_r <= `SWSUB_W_RESET;
      flags_r <= `SWSUB_FLAGS_RESET;
      wr_r <= 1'b0;
      wdata_r <= `SWSUB_DATA_RESET;
    end else begin
      w_r <= w_nxt;
      flags_r <= flags_nxt;
      wr_r <= wr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // Outputs
  always_comb begin
    file_addr = addr_r;
    file_rd = (phase_r == SWSUB_Q2_READ) && active_r && !is_imm_r;
    file_wr = wr_r;
    file_wdata = wdata_r;
    w_out = w_r;
    status_out = flags_r;
    busy = (phase_r != SWSUB_Q1_DECODE);
  end
endmodule : swsub_exec

// [sim/swsub_exec_props.sv]
`timescale 1ns/1ps
// Port-level checks of the subtract datapath
module swsub_exec_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  input wire logic [7:0] file_rdata,
  input wire logic [11:0] file_addr,
  input wire logic file_rd,
  input wire logic file_wr,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] w_out,
  input wire logic [4:0] status_out,
  input wire logic busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Immediate and file forms taken in decode
  wire tk_i = !busy && instr_valid && instr_word[15:8] == 8'h08;
  wire tk_f = !busy && instr_valid && instr_word[15:10] == 6'h17;
  a_busy_span: assert property (tk_i || tk_f |=> busy[*3] ##1 !busy)
    else $error("busy span wrong");
  a_imm_result: assert property (tk_i |-> ##4
    w_out == $past(instr_word[7:0], 4) - $past(w_out, 4))
    else $error("immediate result wrong");
  a_carry_flag: assert property (tk_i |-> ##4
    status_out[0] == ($past(instr_word[7:0], 4) >= $past(w_out, 4)))
    else $error("carry wrong");
  a_ovf_flag: assert property (tk_i |-> ##4
    status_out[3] == (($past(instr_word[7], 4) != $past(w_out[7], 4)) &&
    (w_out[7] != $past(instr_word[7], 4))))
    else $error("overflow wrong");
  a_digit_carry: assert property (tk_i |-> ##4
    status_out[1] == ($past(instr_word[3:0], 4) >= $past(w_out[3:0], 4)))
    else $error("digit carry wrong");
  a_zero_flag: assert property (tk_i |-> ##4 status_out[2] == (w_out == 8'h00))
    else $error("zero wrong");
  a_neg_flag: assert property (tk_i |-> ##4 status_out[4] == w_out[7])
    else $error("negative wrong");
  a_index_addr: assert property (tk_f && ext_set_en && !instr_word[8] && instr_word[7:0] <= 8'h5F |=>
    file_addr == $past(index_base) + $past(instr_word[7:0]))
    else $error("indexed address wrong");
  a_file_write: assert property (tk_f && instr_word[9] |-> ##4
    file_wr && file_wdata == $past(file_rdata, 3) - $past(w_out, 4))
    else $error("file write wrong");
  a_file_to_w: assert property (tk_f && !instr_word[9] |-> ##4
    !file_wr && w_out == $past(file_rdata, 3) - $past(w_out, 4))
    else $error("file result to working register wrong");
  a_file_read: assert property (tk_f |=> file_rd)
    else $error("file read missing");
endmodule : swsub_exec_props

bind swsub_exec swsub_exec_props u_props (.ref_clk(ref_clk), .reset_n(reset_n),
  .instr_valid(instr_valid), .instr_word(instr_word), .ext_set_en(ext_set_en),
  .index_base(index_base), .file_rdata(file_rdata), .file_addr(file_addr), .file_rd(file_rd),
  .file_wr(file_wr), .file_wdata(file_wdata), .w_out(w_out), .status_out(status_out), .busy(busy));

// [sim/swsub_exec_test.sv]
`timescale 1ns/1ps
// Directed bench for the subtract datapath
module swsub_exec_test;
  logic ref_clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_register = 4'h5;
  logic [11:0] index_base = 12'h200, file_addr, fa;
  logic [7:0] file_rdata = 8'h00, file_wdata, w_out, wd;
  logic file_rd, file_wr, busy, wr;
  logic [4:0] status_out;
  int error_cnt = 0, checked = 0, n;
  wire [10:0] wzc = {w_out, status_out[4], status_out[2], status_out[0]};
  always #2.5 ref_clk = ~ref_clk;
  swsub_exec DUT (.ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
    .index_base(index_base), .file_rdata(file_rdata), .file_addr(file_addr), .file_rd(file_rd),
    .file_wr(file_wr), .file_wdata(file_wdata), .w_out(w_out), .status_out(status_out), .busy(busy));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic stop_test;
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // Present one instruction, follow it to completion
  task automatic exec(input logic [15:0] iw, input logic [7:0] rd);
    instr_valid = 1'b1;
    instr_word = iw;
    file_rdata = rd;
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
    fa = file_addr;
    n = 0;
    while (busy === 1'b1 && n < 9) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 9) begin
      error_cnt++;
      stop_test();
    end
    wr = file_wr;
    wd = file_wdata;
  endtask : exec
  // Immediate form with W, N, Z, C and full status expected
  task automatic imm(input logic [7:0] k, input logic [10:0] exp, input logic [4:0] st);
    exec({8'h08, k}, 8'h00);
    check(wzc, exp);
    check(status_out, st);
  endtask : imm
  // Hold reset, release, then check reset values
  task automatic t_reset;
    repeat (4) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    check({w_out, status_out}, 13'h0000);
    check(busy, 1'b0);
  endtask : t_reset
  // Immediate form: positive, zero, positive, borrow
  task automatic t_imm;
    imm(8'h03, 11'h019, 5'h03);
    check(16'(n), 16'h0003);
    imm(8'h03, 11'h003, 5'h07);
    imm(8'h02, 11'h011, 5'h03);
    imm(8'h01, 11'h7FC, 5'h10);
  endtask : t_imm
  // Overflow and digit borrow on the immediate form
  task automatic t_flags;
    imm(8'h01, 11'h009, 5'h03);
    imm(8'h80, 11'h3F9, 5'h09);
  endtask : t_flags
  // Words refused: any word while busy, and an unknown opcode
  task automatic t_refused;
    instr_valid = 1'b1;
    instr_word = 16'h0805;
    @(posedge ref_clk);
    #1;
    instr_word = 16'h0801;
    repeat (3) @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
    check(busy, 1'b0);
    check(w_out, 8'h86);
    @(posedge ref_clk);
    #1;
    exec(16'hFFFF, 8'h00);
    check(16'(n), 16'h0000);
    check(w_out, 8'h86);
  endtask : t_refused
  // File form: destination, access bank, bank select, indexed
  task automatic t_file;
    exec(16'h5E70, 8'h03);
    check({wr, wd}, 9'h104);
    check(fa, 12'hF70);
    exec(16'h5D10, 8'h01);
    check({wr, w_out}, 9'h002);
    check(fa, 12'h510);
    ext_set_en = 1'b1;
    exec(16'h5C5F, 8'h05);
    check(fa, 12'h25F);
    exec(16'h5C60, 8'h03);
    check(fa, 12'hF60);
    check(wzc, 11'h003);
    check(status_out, 5'h07);
  endtask : t_file
  initial begin
    t_reset();
    t_imm();
    t_file();
    t_flags();
    t_refused();
    stop_test();
  end
endmodule : swsub_exec_test
